// ==== src/rtc_pkg.sv ====
package rtc_pkg;
    localparam int NUM_FIELDS = 8;
    localparam int RAM_WORDS  = 10;

    // ram image layout
    localparam logic [3:0] RAM_CTRL  = 4'h0;
    localparam logic [3:0] RAM_FLAGS = 4'h1;
    localparam logic [3:0] RAM_TIME0 = 4'h2;
    localparam logic [3:0] RAM_LAST  = 4'h9;
    localparam logic [3:0] CMD_LOAD  = 4'he;
    localparam logic [3:0] CMD_SNAP  = 4'hf;

    // control_status bits
    localparam int CTRL_FREQ = 0;
    localparam int CTRL_FAST = 2;
    localparam int CTRL_PAR  = 3;
    localparam int CTRL_LOCK = 4;

    // field order inside the running clock
    localparam int F_SEC  = 0;
    localparam int F_MIN  = 1;
    localparam int F_HOUR = 2;
    localparam int F_DAY  = 3;
    localparam int F_MON  = 4;
    localparam int F_YEAR = 5;
    localparam int F_WDAY = 6;
    localparam int F_WEEK = 7;

    localparam logic [7:0] FIELD_LO [NUM_FIELDS] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h00, 8'h01, 8'h00};
    localparam logic [7:0] FIELD_HI [NUM_FIELDS] = '{8'h59, 8'h59, 8'h23, 8'h31, 8'h12, 8'h99, 8'h07, 8'h52};
    // each change flag may only be set while its parent flag is set
    localparam int FLAG_PARENT [NUM_FIELDS] = '{0, 0, 1, 2, 3, 4, 2, 6};

    localparam logic [7:0] MON_FEB   = 8'h02;
    localparam logic [7:0] MON_APR   = 8'h04;
    localparam logic [7:0] MON_JUN   = 8'h06;
    localparam logic [7:0] MON_SEP   = 8'h09;
    localparam logic [7:0] MON_NOV   = 8'h11;
    localparam logic [7:0] DAYS_28   = 8'h28;
    localparam logic [7:0] DAYS_29   = 8'h29;
    localparam logic [7:0] DAYS_30   = 8'h30;
    localparam logic [7:0] WEEK_ZERO = 8'h00;
    localparam logic [7:0] WEEK_ONE  = 8'h01;
    localparam logic [7:0] XMAS_LO   = 8'h25;
    localparam logic [7:0] XMAS_HI   = 8'h27;

    // divider: 32768 Hz oscillator edges
    localparam int          DIV_W    = 15;
    localparam int          FAST_W   = 10;
    localparam int          FREQ_BIT = 6;

    // synchroniser lanes
    localparam int S_OSC = 0;
    localparam int S_CS  = 1;
    localparam int S_RD  = 2;
    localparam int S_WR  = 3;
    localparam int S_IO  = 4;
    localparam int S_W   = 5;
    localparam logic [S_W-1:0] SYNC_RST = 5'h0e;

    localparam logic [2:0] ADDR_LAST_BIT = 3'h3;
    localparam logic [2:0] DATA_LAST_BIT = 3'h7;

    typedef enum logic [1:0] {
        ST_ADDR = 2'b01,
        ST_DATA = 2'b10
    } ser_state_e;
endpackage

// ==== src/cal_if.sv ====
`timescale 1ns/1ps
interface cal_if;
    logic       tick;
    logic       parallel;
    logic       load;
    logic [7:0] load_data [rtc_pkg::NUM_FIELDS];
    logic [7:0] now       [rtc_pkg::NUM_FIELDS];

    modport core    (output tick, output parallel, output load, output load_data, input now);
    modport counter (input tick, input parallel, input load, input load_data, output now);
endinterface

// ==== src/cal_counter.sv ====
`timescale 1ns/1ps
module cal_counter (
    input wire logic clock,
    input wire logic clock_en,
    input wire logic arst_n,
    cal_if.counter   cal
);
    logic [7:0] f_q   [rtc_pkg::NUM_FIELDS];
    logic [7:0] inc_v [rtc_pkg::NUM_FIELDS];
    logic [7:0] mend;
    logic       c_min;
    logic       c_hour;
    logic       c_day;
    logic       c_mon;
    logic       c_year;
    logic       wd_wrap;
    logic       xmas;

    function automatic logic bcd_ok(input logic [7:0] v, input logic [7:0] lo, input logic [7:0] hi);
        return (v[3:0] <= 4'h9) && (v[7:4] <= 4'h9) && (v >= lo) && (v <= hi);
    endfunction

    // out-of-range values fall back to the field's cleared value
    function automatic logic [7:0] bcd_inc(input logic [7:0] v, input logic [7:0] lo, input logic [7:0] hi);
        if (!bcd_ok(v, lo, hi) || v == hi)
            return lo; // RULE9
        else if (v[3:0] == 4'h9)
            return {v[7:4] + 4'h1, 4'h0};
        else
            return {v[7:4], v[3:0] + 4'h1};
    endfunction

    // two-digit year: leap when divisible by four
    always_comb begin
        logic leap;
        leap = f_q[rtc_pkg::F_YEAR][4] ? (f_q[rtc_pkg::F_YEAR][3:0] == 4'h2 || f_q[rtc_pkg::F_YEAR][3:0] == 4'h6)
                                       : (f_q[rtc_pkg::F_YEAR][3:0] == 4'h0 || f_q[rtc_pkg::F_YEAR][3:0] == 4'h4
                                          || f_q[rtc_pkg::F_YEAR][3:0] == 4'h8);
        if (f_q[rtc_pkg::F_MON] == rtc_pkg::MON_FEB)
            mend = leap ? rtc_pkg::DAYS_29 : rtc_pkg::DAYS_28; // RULE10
        else if (f_q[rtc_pkg::F_MON] == rtc_pkg::MON_APR || f_q[rtc_pkg::F_MON] == rtc_pkg::MON_JUN
                 || f_q[rtc_pkg::F_MON] == rtc_pkg::MON_SEP || f_q[rtc_pkg::F_MON] == rtc_pkg::MON_NOV)
            mend = rtc_pkg::DAYS_30;
        else
            mend = rtc_pkg::FIELD_HI[rtc_pkg::F_DAY];
    end

    for (genvar i = 0; i < rtc_pkg::NUM_FIELDS; i++) begin : g_field
        assign inc_v[i] = bcd_inc(f_q[i], rtc_pkg::FIELD_LO[i], (i == rtc_pkg::F_DAY) ? mend : rtc_pkg::FIELD_HI[i]);
        assign cal.now[i] = f_q[i];
    end

    assign c_min   = f_q[rtc_pkg::F_SEC] == rtc_pkg::FIELD_HI[rtc_pkg::F_SEC];
    assign c_hour  = c_min && f_q[rtc_pkg::F_MIN] == rtc_pkg::FIELD_HI[rtc_pkg::F_MIN];
    assign c_day   = c_hour && f_q[rtc_pkg::F_HOUR] == rtc_pkg::FIELD_HI[rtc_pkg::F_HOUR];
    assign c_mon   = c_day && f_q[rtc_pkg::F_DAY] == mend;
    assign c_year  = c_mon && f_q[rtc_pkg::F_MON] == rtc_pkg::FIELD_HI[rtc_pkg::F_MON];
    assign wd_wrap = c_day && f_q[rtc_pkg::F_WDAY] == rtc_pkg::FIELD_HI[rtc_pkg::F_WDAY];
    assign xmas    = f_q[rtc_pkg::F_MON] == rtc_pkg::FIELD_HI[rtc_pkg::F_MON]
                     && f_q[rtc_pkg::F_DAY] >= rtc_pkg::XMAS_LO && f_q[rtc_pkg::F_DAY] <= rtc_pkg::XMAS_HI;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < rtc_pkg::NUM_FIELDS; i++) begin
                f_q[i] <= rtc_pkg::FIELD_LO[i];
            end
        end else if (clock_en) begin
            if (cal.load) begin
                f_q <= cal.load_data; // RULE25
            end else if (cal.tick && cal.parallel) begin
                f_q <= inc_v; // RULE19 RULE20
            end else if (cal.tick) begin
                // normal carries, BCD throughout
                f_q[rtc_pkg::F_SEC] <= inc_v[rtc_pkg::F_SEC]; // RULE8
                if (c_min)
                    f_q[rtc_pkg::F_MIN] <= inc_v[rtc_pkg::F_MIN];
                if (c_hour)
                    f_q[rtc_pkg::F_HOUR] <= inc_v[rtc_pkg::F_HOUR];
                if (c_day) begin
                    f_q[rtc_pkg::F_DAY]  <= inc_v[rtc_pkg::F_DAY];
                    f_q[rtc_pkg::F_WDAY] <= inc_v[rtc_pkg::F_WDAY]; // RULE13
                end
                if (c_mon)
                    f_q[rtc_pkg::F_MON] <= inc_v[rtc_pkg::F_MON];
                if (c_year)
                    f_q[rtc_pkg::F_YEAR] <= inc_v[rtc_pkg::F_YEAR];
                if (wd_wrap) begin // RULE11
                    if (f_q[rtc_pkg::F_WEEK] == rtc_pkg::FIELD_HI[rtc_pkg::F_WEEK])
                        f_q[rtc_pkg::F_WEEK] <= xmas ? rtc_pkg::WEEK_ZERO : rtc_pkg::WEEK_ONE; // RULE12
                    else
                        f_q[rtc_pkg::F_WEEK] <= inc_v[rtc_pkg::F_WEEK]; // RULE10
                end
            end
        end
    end

    default clocking @(posedge clock); endclocking
    default disable iff (!arst_n);

    week_only_wrap_a: assert property (clock_en && !cal.load && !cal.parallel // RULE11
        && f_q[rtc_pkg::F_WDAY] != rtc_pkg::FIELD_HI[rtc_pkg::F_WDAY] |=> $stable(f_q[rtc_pkg::F_WEEK]))
        else $error("week number moved without weekday wrap");
    range_clear_a: assert property (clock_en && cal.tick && !cal.load // RULE9
        && f_q[rtc_pkg::F_SEC] > rtc_pkg::FIELD_HI[rtc_pkg::F_SEC] |=> f_q[rtc_pkg::F_SEC] == rtc_pkg::FIELD_LO[rtc_pkg::F_SEC])
        else $error("out of range seconds not cleared");
endmodule

// ==== src/rtc_core.sv ====
// Functional notes
// [RULE1] host writes zero to control_status then loads time after power failure
// [RULE2] snapshot updates every change flag against the previous snapshot
// [RULE3] seconds flag bit 0 is set exactly when seconds changed
// [RULE4] a flag for a larger unit needs all smaller-unit flags set
// [RULE5] clock load clears all change flags
// [RULE6] lock bit 4 of control_status makes clock load ignored
// [RULE7] host programs the lock bit after power failure
// [RULE8] all eight fields kept and counted in packed BCD within range
// [RULE9] out-of-range field clears on its next increment
// [RULE10] leap-year month end and automatic week number
// [RULE11] week number advances only when weekday wraps 7 to 1
// [RULE12] week 52 day 7 on December 25-27 goes to week 0, else 1
// [RULE13] weekday counts 1 to 7, Monday is 1
// [RULE14] snapshot values in the ram image stay until next snapshot
// [RULE15] host issues a snapshot before reading time
// [RULE16] host writes ram, clears lock, then issues clock load
// [RULE17] control bit 0 and chip select high pulse data pin at 256 Hz
// [RULE18] bit 2 alone speeds timekeeping by 32 with carries
// [RULE19] bit 3 alone increments all fields each second without carry
// [RULE20] both test bits give carry-free parallel increment 32 times a second
// [RULE21] host clears test bits and reloads time after testing
// [RULE22] divider accepts external drive up to 128 kHz, combined with tests
// [RULE23] no interrupt output, host polls the change flags
// [RULE24] address codes e and f end the cycle and run load or snapshot
// [RULE25] clock load copies ram addresses 2 to 9 into the running clock
// [RULE26] ram image: status at 0 and 1, time 2 to 5, date 6 to 9; the core puts day of month at 5 and month at 6
// [RULE27] one-second tick by binary division of the 32768 Hz oscillator
// [RULE28] time updates never stall a host access, no busy indication
`timescale 1ns/1ps
module rtc_core (
    input  wire logic clock,
    input  wire logic clock_en,
    input  wire logic arst_n,
    input  wire logic osc_out_pin,
    input  wire logic cs_n,
    input  wire logic rd_n,
    input  wire logic wr_n,
    input  wire logic io_in,
    output logic      io_out,
    output logic      io_oe_n
);
    cal_if cal ();

    logic [rtc_pkg::S_W-1:0]   sync1_q;
    logic [rtc_pkg::S_W-1:0]   sync2_q;
    logic                      osc_prev_q;
    logic [rtc_pkg::DIV_W-1:0] div_q;
    logic                      wr_prev_q;
    logic                      rd_prev_q;
    rtc_pkg::ser_state_e       state_q;
    logic [2:0]                cnt_q;
    logic [3:0]                addr_q;
    logic [7:0]                shift_q;
    logic [7:0]                ram_q  [rtc_pkg::RAM_WORDS];
    logic [7:0]                prev_q [rtc_pkg::NUM_FIELDS];
    logic                      io_out_q;
    logic                      io_oe_n_q;

    logic       osc_rise;
    logic       tick_sec;
    logic       tick_fast;
    logic       wr_act;
    logic       rd_act;
    logic       wr_end;
    logic       rd_end;
    logic       io_bit;
    logic [3:0] addr_full;
    logic       cmd_word;
    logic       load_go;
    logic       snap_go;
    logic       commit;
    logic       rd_bit;
    logic       freq_on;
    logic [7:0] flags;
    logic       io_out_d;
    logic       io_oe_n_d;

    // every pin and the oscillator are asynchronous to clock
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            sync1_q <= rtc_pkg::SYNC_RST;
            sync2_q <= rtc_pkg::SYNC_RST;
        end else if (clock_en) begin
            sync1_q <= {io_in, wr_n, rd_n, cs_n, osc_out_pin};
            sync2_q <= sync1_q;
        end
    end

    // binary divider on oscillator edges; works for any drive rate far below clock
    assign osc_rise  = sync2_q[rtc_pkg::S_OSC] && !osc_prev_q; // RULE22
    assign tick_sec  = osc_rise && (&div_q); // RULE27
    assign tick_fast = osc_rise && (&div_q[rtc_pkg::FAST_W-1:0]);

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            osc_prev_q <= 1'b0;
            div_q      <= '0;
        end else if (clock_en) begin
            osc_prev_q <= sync2_q[rtc_pkg::S_OSC];
            if (osc_rise)
                div_q <= div_q + rtc_pkg::DIV_W'(1); // RULE27
        end
    end

    // test modes pick the rate and the carry behaviour independently
    // ticks touch only the hidden clock, never the serial state, so access never stalls
    assign cal.tick     = ram_q[rtc_pkg::RAM_CTRL][rtc_pkg::CTRL_FAST] ? tick_fast : tick_sec; // RULE18 RULE20 RULE28
    assign cal.parallel = ram_q[rtc_pkg::RAM_CTRL][rtc_pkg::CTRL_PAR]; // RULE19
    assign cal.load     = load_go;

    for (genvar i = 0; i < rtc_pkg::NUM_FIELDS; i++) begin : g_load
        assign cal.load_data[i] = ram_q[i + rtc_pkg::RAM_TIME0]; // RULE25 RULE26
    end

    cal_counter u_counter (
        .clock    (clock),
        .clock_en (clock_en),
        .arst_n   (arst_n),
        .cal      (cal.counter)
    );

    // serial access: bits are taken when the strobe pulse ends
    assign wr_act    = !sync2_q[rtc_pkg::S_CS] && !sync2_q[rtc_pkg::S_WR];
    assign rd_act    = !sync2_q[rtc_pkg::S_CS] && !sync2_q[rtc_pkg::S_RD];
    assign wr_end    = wr_prev_q && !wr_act;
    assign rd_end    = rd_prev_q && !rd_act;
    assign io_bit    = sync2_q[rtc_pkg::S_IO];
    assign addr_full = {io_bit, addr_q[2:0]};
    assign cmd_word  = wr_end && state_q == rtc_pkg::ST_ADDR && cnt_q == rtc_pkg::ADDR_LAST_BIT;
    assign load_go   = cmd_word && addr_full == rtc_pkg::CMD_LOAD
                       && !ram_q[rtc_pkg::RAM_CTRL][rtc_pkg::CTRL_LOCK]; // RULE6
    assign snap_go   = cmd_word && addr_full == rtc_pkg::CMD_SNAP; // RULE24
    assign commit    = wr_end && state_q == rtc_pkg::ST_DATA && cnt_q == rtc_pkg::DATA_LAST_BIT
                       && addr_q <= rtc_pkg::RAM_LAST;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            wr_prev_q <= 1'b0;
            rd_prev_q <= 1'b0;
        end else if (clock_en) begin
            wr_prev_q <= wr_act;
            rd_prev_q <= rd_act;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= rtc_pkg::ST_ADDR;
            cnt_q   <= '0;
            addr_q  <= '0;
            shift_q <= '0;
        end else if (clock_en) begin
            if (wr_end) begin
                unique case (state_q)
                    rtc_pkg::ST_ADDR: begin
                        addr_q[cnt_q[1:0]] <= io_bit;
                        if (cnt_q == rtc_pkg::ADDR_LAST_BIT) begin
                            cnt_q <= '0;
                            // command codes end the cycle at once
                            if (addr_full < rtc_pkg::CMD_LOAD)
                                state_q <= rtc_pkg::ST_DATA; // RULE24
                        end else begin
                            cnt_q <= cnt_q + 3'h1;
                        end
                    end
                    rtc_pkg::ST_DATA: begin
                        shift_q <= {io_bit, shift_q[7:1]};
                        if (cnt_q == rtc_pkg::DATA_LAST_BIT) begin
                            cnt_q   <= '0;
                            state_q <= rtc_pkg::ST_ADDR;
                        end else begin
                            cnt_q <= cnt_q + 3'h1;
                        end
                    end
                endcase
            end else if (rd_end) begin
                unique case (state_q)
                    // reads cannot open a cycle; they realign the address count instead
                    rtc_pkg::ST_ADDR: cnt_q <= '0;
                    rtc_pkg::ST_DATA: begin
                        if (cnt_q == rtc_pkg::DATA_LAST_BIT) begin
                            cnt_q   <= '0;
                            state_q <= rtc_pkg::ST_ADDR;
                        end else begin
                            cnt_q <= cnt_q + 3'h1;
                        end
                    end
                endcase
            end
        end
    end

    // change flags, masked so a larger unit never shows without its smaller ones
    // no interrupt line: the host polls these after each snapshot (RULE23)
    always_comb begin
        flags = '0;
        for (int i = 0; i < rtc_pkg::NUM_FIELDS; i++) begin
            flags[i] = cal.now[i] != prev_q[i]; // RULE2 RULE23
            if (i != rtc_pkg::F_SEC)
                flags[i] = flags[i] && flags[rtc_pkg::FLAG_PARENT[i]]; // RULE4
        end
    end

    // ram image: host writes, snapshot and load are the only writers
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < rtc_pkg::RAM_WORDS; i++) begin
                ram_q[i] <= '0;
            end
        end else if (clock_en) begin
            if (commit) begin
                ram_q[addr_q] <= {io_bit, shift_q[7:1]}; // RULE1 RULE16
            end else if (snap_go) begin
                ram_q[rtc_pkg::RAM_FLAGS] <= flags; // RULE3
                for (int i = 0; i < rtc_pkg::NUM_FIELDS; i++) begin
                    ram_q[i + rtc_pkg::RAM_TIME0] <= cal.now[i]; // RULE14
                end
            end else if (load_go) begin
                ram_q[rtc_pkg::RAM_FLAGS] <= '0; // RULE5
            end
        end
    end

    // reference for the next snapshot's comparison
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < rtc_pkg::NUM_FIELDS; i++) begin
                prev_q[i] <= rtc_pkg::FIELD_LO[i];
            end
        end else if (clock_en) begin
            if (snap_go)
                prev_q <= cal.now; // RULE2
            else if (load_go)
                prev_q <= cal.load_data; // RULE5
        end
    end

    // data pin: read data while strobed, otherwise the weak 256 Hz pulse
    assign rd_bit  = (addr_q <= rtc_pkg::RAM_LAST) ? ram_q[addr_q][cnt_q] : 1'b0;
    assign freq_on = ram_q[rtc_pkg::RAM_CTRL][rtc_pkg::CTRL_FREQ] && sync2_q[rtc_pkg::S_CS]
                     && div_q[rtc_pkg::FREQ_BIT]; // RULE17

    always_comb begin
        io_out_d  = 1'b1;
        io_oe_n_d = 1'b1;
        if (rd_act && state_q == rtc_pkg::ST_DATA) begin
            io_out_d  = rd_bit;
            io_oe_n_d = 1'b0;
        end else if (freq_on) begin
            io_oe_n_d = 1'b0; // RULE17
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            io_out_q  <= 1'b1;
            io_oe_n_q <= 1'b1;
        end else if (clock_en) begin
            io_out_q  <= io_out_d;
            io_oe_n_q <= io_oe_n_d;
        end
    end

    assign io_out  = io_out_q;
    assign io_oe_n = io_oe_n_q;

    default clocking @(posedge clock); endclocking
    default disable iff (!arst_n);

    seconds_flag_a: assert property (clock_en && snap_go // RULE3
        |=> ram_q[rtc_pkg::RAM_FLAGS][rtc_pkg::F_SEC] == (ram_q[rtc_pkg::RAM_TIME0] != $past(prev_q[rtc_pkg::F_SEC])))
        else $error("seconds flag does not match seconds change");
    flag_order_a: assert property (clock_en && snap_go |=> // RULE4
        (!ram_q[1][1] || ram_q[1][0]) && (!ram_q[1][2] || ram_q[1][1]) && (!ram_q[1][3] || ram_q[1][2])
        && (!ram_q[1][5] || ram_q[1][4]) && (!ram_q[1][7] || ram_q[1][6]) && (!ram_q[1][6] || ram_q[1][2]))
        else $error("change flags out of hierarchy");
    load_clears_a: assert property (clock_en && load_go |=> ram_q[rtc_pkg::RAM_FLAGS] == 8'h00 // RULE5
        && cal.now[rtc_pkg::F_SEC] == $past(ram_q[rtc_pkg::RAM_TIME0]))
        else $error("clock load did not clear flags or copy time");
    lock_blocks_a: assert property (clock_en && cmd_word && addr_full == rtc_pkg::CMD_LOAD // RULE6
        && ram_q[rtc_pkg::RAM_CTRL][rtc_pkg::CTRL_LOCK] |=> $stable(ram_q[rtc_pkg::RAM_FLAGS]))
        else $error("locked clock load took effect");
    snap_hold_a: assert property (clock_en && !snap_go && !commit |=> $stable(ram_q[rtc_pkg::RAM_TIME0])) // RULE14
        else $error("snapshot seconds changed without snapshot");
    cmd_ends_a: assert property (clock_en && cmd_word && addr_full >= rtc_pkg::CMD_LOAD // RULE24
        |=> state_q == rtc_pkg::ST_ADDR && cnt_q == 3'h0)
        else $error("command code did not end the cycle");
    freq_pulse_a: assert property (clock_en && freq_on |=> !io_oe_n_q && io_out_q) // RULE17
        else $error("frequency pulse not driven");
    tick_rate_a: assert property (cal.tick |-> osc_rise && (&div_q[rtc_pkg::FAST_W-1:0])) // RULE18
        else $error("clock tick off the divider");
endmodule

// ==== sim/host_model.sv ====
`timescale 1ns/1ps
module host_model (
    input  wire logic clock,
    input  wire logic io_out,
    input  wire logic io_oe_n,
    output logic      cs_n,
    output logic      rd_n,
    output logic      wr_n,
    output logic      io_in
);
    logic drv;
    // released line floats: inverse of last value, never a stale copy
    assign io_in = (io_oe_n === 1'b0) ? io_out : drv;
    initial begin
        cs_n = 1'b1;
        rd_n = 1'b1;
        wr_n = 1'b1;
        drv  = 1'b0;
    end
    task automatic pulse(input logic wr, input logic d, output logic q);
        @(negedge clock);
        drv  = wr ? d : ~drv;
        cs_n = 1'b0;
        rd_n = wr;
        wr_n = ~wr;
        repeat (4) @(negedge clock);
        q    = io_in;
        cs_n = 1'b1;
        rd_n = 1'b1;
        wr_n = 1'b1;
        repeat (5) @(negedge clock);
    endtask
    // whole cycle: 4 address bits lsb first, then 8 data bits unless a command
    task automatic xfer(input logic [3:0] a, input logic wr, inout logic [7:0] d);
        logic q;
        for (int i = 0; i < 4; i++) pulse(1'b1, a[i], q);
        if (a < rtc_pkg::CMD_LOAD) begin
            for (int i = 0; i < 8; i++) begin
                pulse(wr, d[i], q);
                if (!wr) d[i] = q;
            end
        end
    endtask
endmodule

// ==== sim/bcd_calendar_core_test.sv ====
`timescale 1ns/1ps
module bcd_calendar_core_test;
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    logic osc = 1'b0;
    logic cs_n, rd_n, wr_n, io_in, io_out, io_oe_n;
    int   num_errors = 0;
    int   comparisons = 0;
    // ctrl, load sec..week, expected sec..week, expected flags
    localparam logic [7:0] ROWS [5][18] = '{
        '{8'h04, 8'h59, 8'h59, 8'h23, 8'h31, 8'h12, 8'h99, 8'h07, 8'h52,
          8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h00, 8'h01, 8'h01, 8'hff},
        '{8'h04, 8'h59, 8'h59, 8'h23, 8'h26, 8'h12, 8'h05, 8'h07, 8'h52,
          8'h00, 8'h00, 8'h00, 8'h27, 8'h12, 8'h05, 8'h01, 8'h00, 8'hcf},
        '{8'h04, 8'h59, 8'h59, 8'h23, 8'h28, 8'h02, 8'h04, 8'h03, 8'h09,
          8'h00, 8'h00, 8'h00, 8'h29, 8'h02, 8'h04, 8'h04, 8'h09, 8'h4f},
        '{8'h04, 8'h59, 8'h59, 8'h23, 8'h28, 8'h02, 8'h03, 8'h03, 8'h09,
          8'h00, 8'h00, 8'h00, 8'h01, 8'h03, 8'h03, 8'h04, 8'h09, 8'h5f},
        '{8'h0c, 8'h75, 8'h10, 8'h05, 8'h05, 8'h05, 8'h05, 8'h03, 8'h05,
          8'h00, 8'h11, 8'h06, 8'h06, 8'h06, 8'h06, 8'h04, 8'h06, 8'hff}};
    initial forever #5 clock = ~clock;
    initial forever #40 osc = ~osc;
    host_model u_host (.clock(clock), .io_out(io_out), .io_oe_n(io_oe_n),
                       .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .io_in(io_in));
    rtc_core u_dut (.clock(clock), .clock_en(1'b1), .arst_n(arst_n), .osc_out_pin(osc),
                    .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .io_in(io_in),
                    .io_out(io_out), .io_oe_n(io_oe_n));
    task automatic report_and_stop();
        $display("comparisons %0d num_errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        u_host.xfer(a, 1'b1, d);
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        d = 8'h00;
        u_host.xfer(a, 1'b0, d);
    endtask
    task automatic ram_access();
        logic [7:0] d;
        wr(rtc_pkg::RAM_TIME0, 8'ha5);
        rd(rtc_pkg::RAM_TIME0, d);
        check(d, 8'ha5);
        rd(4'ha, d);
        check(d, 8'h00);
    endtask
    task automatic lock_load();
        logic [7:0] d;
        wr(rtc_pkg::RAM_CTRL, 8'h10);
        wr(rtc_pkg::RAM_FLAGS, 8'h5a);
        wr(rtc_pkg::CMD_LOAD, d);
        rd(rtc_pkg::RAM_FLAGS, d);
        check(d, 8'h5a);
        wr(rtc_pkg::RAM_CTRL, 8'h00);
        wr(rtc_pkg::CMD_LOAD, d);
        rd(rtc_pkg::RAM_FLAGS, d);
        check(d, 8'h00);
    endtask
    task automatic run_row(input int r);
        logic [7:0] d;
        int         n;
        wr(rtc_pkg::RAM_CTRL, ROWS[r][0]);
        for (int i = 0; i < 8; i++) wr(rtc_pkg::RAM_TIME0 + 4'(i), ROWS[r][1+i]);
        wr(rtc_pkg::CMD_LOAD, d);
        d = 8'h00;
        n = 0;
        // polling only; the core has no completion signal
        while (d[0] !== 1'b1 && n < 100) begin
            wr(rtc_pkg::CMD_SNAP, d);
            rd(rtc_pkg::RAM_FLAGS, d);
            n++;
        end
        if (n == 100) begin
            num_errors++;
            report_and_stop();
        end
        check(d, ROWS[r][17]);
        wr(rtc_pkg::CMD_SNAP, d);
        rd(rtc_pkg::RAM_FLAGS, d);
        check(d, 8'h00);
        for (int i = 0; i < 8; i++) begin
            rd(rtc_pkg::RAM_TIME0 + 4'(i), d);
            check(d, ROWS[r][9+i]);
        end
    endtask
    task automatic freq_pulse();
        int lo;
        int hi;
        lo = 0;
        hi = 0;
        wr(rtc_pkg::RAM_CTRL, 8'h01);
        repeat (3000) begin
            @(negedge clock);
            if (io_oe_n === 1'b0 && io_out === 1'b1) lo++;
            if (io_oe_n === 1'b1) hi++;
        end
        check(8'(lo > 400), 8'h01);
        check(8'(hi > 400), 8'h01);
        wr(rtc_pkg::RAM_CTRL, 8'h00);
    endtask
    initial begin
        repeat (12) @(negedge clock);
        arst_n = 1'b1;
        repeat (2) @(negedge clock);
        wr(rtc_pkg::RAM_CTRL, 8'h00);
        ram_access();
        lock_load();
        for (int r = 0; r < 5; r++) run_row(r);
        wr(rtc_pkg::RAM_CTRL, 8'h00);
        freq_pulse();
        report_and_stop();
    end
endmodule
